// >>> verilog/jtbs_top.v
// Test access port with instruction decode, data registers and boundary pin mapping
`timescale 1ns/100ps
`default_nettype none
`include "jtbs_consts.vh"

module jtbs_top #(
    parameter [`JTBS_ID_W-1:0] ID_VALUE  = `JTBS_ID_DEFAULT,
    parameter                  LARGE_PKG = 1,
    parameter                  PINS      = `JTBS_PORT_PINS
) (
    input  wire                       mclk,
    input  wire                       rstn,
    input  wire                       tck,
    input  wire                       tms,
    input  wire                       tdi,
    output reg                        tdo,
    output reg                        tdo_oe,
    input  wire                       core_rst_en,
    input  wire                       core_rst_level,
    input  wire                       core_pullup_en,
    input  wire [PINS-1:0]            core_port_oe,
    input  wire [PINS-1:0]            core_port_out,
    input  wire                       rst_pin_in,
    input  wire                       xtal_pin_in,
    input  wire [PINS-1:0]            port_pin_in,
    output reg                        rst_pin_oe,
    output reg                        rst_pin_out,
    output reg                        pullup_en_out,
    output reg  [PINS-1:0]            port_pin_oe,
    output reg  [PINS-1:0]            port_pin_out,
    output reg                        core_rst_in,
    output reg                        core_xtal_in,
    output reg  [PINS-1:0]            core_port_in,
    input  wire                       flash_busy,
    input  wire [`JTBS_FL_DATA_W-1:0] flash_read_data,
    output reg                        flash_req,
    output reg  [1:0]                 flash_req_sel,
    output reg  [1:0]                 flash_req_op,
    output reg  [`JTBS_FL_DATA_W-1:0] flash_req_data,
    output reg                        extest_active,
    output reg  [`JTBS_IR_W-1:0]      instruction
);
    // TAP state codes, mirroring the controller
    localparam [3:0] ST_TLR  = 4'h0;
    localparam [3:0] ST_CDR  = 4'h3;
    localparam [3:0] ST_SHDR = 4'h4;
    localparam [3:0] ST_UDR  = 4'h8;
    localparam [3:0] ST_CIR  = 4'hA;
    localparam [3:0] ST_SHIR = 4'hB;
    localparam [3:0] ST_UIR  = 4'hF;

    localparam LEN = `JTBS_BSR_LEN;
    localparam PW  = PINS + 2;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts once stages two and three agree

    reg  [2:0]    jt_s1;
    reg  [2:0]    jt_s2;
    reg  [2:0]    jt_s3;
    reg  [2:0]    jt_f;
    wire [2:0]    next_jt_f;
    reg  [PW-1:0] pin_s1;
    reg  [PW-1:0] pin_s2;
    reg  [PW-1:0] pin_s3;
    reg  [PW-1:0] pin_f;
    wire [PW-1:0] next_pin_f;

    // Bitwise majority of agreeing stages, otherwise hold
    assign next_jt_f  = (jt_s2 & jt_s3) | (jt_f & (jt_s2 | jt_s3));
    assign next_pin_f = (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            jt_s1  <= 3'h0;
            jt_s2  <= 3'h0;
            jt_s3  <= 3'h0;
            jt_f   <= 3'h0;
            pin_s1 <= {PW{1'b0}};
            pin_s2 <= {PW{1'b0}};
            pin_s3 <= {PW{1'b0}};
            pin_f  <= {PW{1'b0}};
        end else begin
            jt_s1  <= {tck, tms, tdi};
            jt_s2  <= jt_s1;
            jt_s3  <= jt_s2;
            jt_f   <= next_jt_f;
            pin_s1 <= {rst_pin_in, xtal_pin_in, port_pin_in};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f  <= next_pin_f;
        end
    end

    wire          tck_rise = next_jt_f[2] & ~jt_f[2];
    wire          tck_fall = ~next_jt_f[2] & jt_f[2];
    wire          tms_bit  = next_jt_f[1];
    wire          tdi_bit  = next_jt_f[0];
    wire [PINS-1:0] pin_in_f = pin_f[PINS-1:0];
    wire          xtal_f   = pin_f[PINS];
    wire          rst_f    = pin_f[PINS+1];

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Controller and instruction decode

    wire [3:0] state;

    jtbs_tap_fsm u_fsm (
        .mclk     (mclk),
        .rstn     (rstn),
        .tck_rise (tck_rise),
        .tms_bit  (tms_bit),
        .state    (state)
    );

    wire in_tlr  = (state == ST_TLR);
    wire cap_dr  = tck_rise & (state == ST_CDR);
    wire sh_dr   = tck_rise & (state == ST_SHDR);
    wire upd_dr  = tck_fall & (state == ST_UDR);
    wire cap_ir  = tck_rise & (state == ST_CIR);
    wire sh_ir   = tck_rise & (state == ST_SHIR);
    wire upd_ir  = tck_fall & (state == ST_UIR);

    wire is_extest = (instruction == `JTBS_OP_EXTEST);
    wire is_sample = (instruction == `JTBS_OP_SAMPLE);
    wire is_id     = (instruction == `JTBS_OP_IDCODE);
    wire is_fctl   = (instruction == `JTBS_OP_FLASH_CTL);
    wire is_fdat   = (instruction == `JTBS_OP_FLASH_DAT);
    wire is_fadr   = (instruction == `JTBS_OP_FLASH_ADR);
    wire is_fscl   = (instruction == `JTBS_OP_FLASH_SCL);
    wire is_flash  = is_fctl | is_fdat | is_fadr | is_fscl;
    wire is_bsr    = is_extest | is_sample;
    // Anything else, 0xFFFF included, falls to bypass
    wire is_bypass = ~(is_bsr | is_id | is_flash);

    reg [1:0] flash_sel_code;

    always @* begin
        case (1'b1)
            is_fctl: flash_sel_code = 2'h0;
            is_fdat: flash_sel_code = 2'h1;
            is_fadr: flash_sel_code = 2'h2;
            is_fscl: flash_sel_code = 2'h3;
            default: flash_sel_code = 2'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Instruction register

    reg [`JTBS_IR_W-1:0] ir_sh;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ir_sh       <= `JTBS_IR_RESET;
            instruction <= `JTBS_IR_RESET;
        end else begin
            if (cap_ir) begin
                ir_sh <= `JTBS_IR_CAPTURE;
            end else if (sh_ir) begin
                ir_sh <= {tdi_bit, ir_sh[`JTBS_IR_W-1:1]};
            end
            if (in_tlr) begin
                instruction <= `JTBS_IR_RESET;
            end else if (upd_ir) begin
                instruction <= ir_sh;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Identification, bypass and flash windows share one shift register

    reg [`JTBS_ID_W-1:0] dr_sh;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dr_sh <= {`JTBS_ID_W{1'b0}};
        end else if (cap_dr) begin
            if (is_id) begin
                dr_sh <= ID_VALUE;
            end else if (is_flash) begin
                // Busy sits at bit 0 so a single shift polls it
                dr_sh <= {12'h000, 1'b0, flash_read_data, flash_busy};
            end else begin
                dr_sh <= {`JTBS_ID_W{1'b0}};
            end
        end else if (sh_dr) begin
            if (is_id) begin
                dr_sh <= {tdi_bit, dr_sh[`JTBS_ID_W-1:1]};
            end else if (is_flash) begin
                // Entry at bit 19 leaves short writes left-justified
                dr_sh <= {12'h000, tdi_bit, dr_sh[`JTBS_FL_W-1:1]};
            end else if (is_bypass) begin
                dr_sh <= {31'h0000_0000, tdi_bit};
            end
        end
    end

    // Poll opcodes carry no update, so only read and write reach the core
    wire [1:0] fl_op = dr_sh[`JTBS_FL_OP_HI:`JTBS_FL_OP_LO];
    wire fl_go = upd_dr & is_flash & fl_op[1];

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flash_req      <= 1'b0;
            flash_req_sel  <= 2'h0;
            flash_req_op   <= 2'h0;
            flash_req_data <= {`JTBS_FL_DATA_W{1'b0}};
        end else begin
            flash_req <= fl_go;
            if (fl_go) begin
                flash_req_sel  <= flash_sel_code;
                flash_req_op   <= fl_op;
                flash_req_data <= dr_sh[`JTBS_FL_DATA_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Boundary chain: capture map and update decode

    wire [LEN-1:0] bsr_cap;
    wire [LEN-1:0] bsr_upd;
    wire [PINS-1:0] ext_oe;
    wire [PINS-1:0] ext_out;
    wire           bsr_tdo;

    // Both reset pairs capture; only the fitted package's pair drives
    assign bsr_cap[`JTBS_BSR_RST_SMALL]   = core_rst_en;
    assign bsr_cap[`JTBS_BSR_RST_SMALL+1] = rst_f;
    assign bsr_cap[`JTBS_BSR_RST_LARGE]   = core_rst_en;
    assign bsr_cap[`JTBS_BSR_RST_LARGE+1] = rst_f;
    assign bsr_cap[`JTBS_BSR_XTAL]        = xtal_f;
    assign bsr_cap[`JTBS_BSR_PULLUP]      = core_pullup_en;

    genvar g;
    generate
        for (g = 0; g < PINS; g = g + 1) begin : g_port
            assign bsr_cap[`JTBS_BSR_PORT0+2*g]   = core_port_oe[g];
            assign bsr_cap[`JTBS_BSR_PORT0+2*g+1] = pin_in_f[g];
            assign ext_oe[g]                      = bsr_upd[`JTBS_BSR_PORT0+2*g];
            assign ext_out[g]                     = bsr_upd[`JTBS_BSR_PORT0+2*g+1];
        end
    endgenerate

    jtbs_bsr #(
        .LEN (LEN)
    ) u_bsr (
        .mclk    (mclk),
        .rstn    (rstn),
        .capture (cap_dr & is_bsr),
        .shift   (sh_dr & is_bsr),
        .update  (upd_dr & is_bsr),
        .tdi_bit (tdi_bit),
        .cap_vec (bsr_cap),
        .tdo_bit (bsr_tdo),
        .upd_vec (bsr_upd)
    );

    localparam RST_BIT = LARGE_PKG ? `JTBS_BSR_RST_LARGE : `JTBS_BSR_RST_SMALL;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Pin and core-side drivers, registered; latches reach pins only in the drive test

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            extest_active <= 1'b0;
            rst_pin_oe    <= 1'b0;
            rst_pin_out   <= 1'b0;
            pullup_en_out <= 1'b0;
            port_pin_oe   <= {PINS{1'b0}};
            port_pin_out  <= {PINS{1'b0}};
            core_rst_in   <= 1'b1;
            core_xtal_in  <= 1'b1;
            core_port_in  <= {PINS{1'b1}};
        end else begin
            extest_active <= is_extest;
            if (is_extest) begin
                rst_pin_oe    <= bsr_upd[RST_BIT];
                rst_pin_out   <= bsr_upd[RST_BIT+1];
                pullup_en_out <= bsr_upd[`JTBS_BSR_PULLUP];
                port_pin_oe   <= ext_oe;
                port_pin_out  <= ext_out;
                core_rst_in   <= 1'b1;
                core_xtal_in  <= 1'b1;
                core_port_in  <= {PINS{1'b1}};
            end else begin
                rst_pin_oe    <= core_rst_en;
                rst_pin_out   <= core_rst_level;
                pullup_en_out <= core_pullup_en;
                port_pin_oe   <= core_port_oe;
                port_pin_out  <= core_port_out;
                core_rst_in   <= rst_f;
                core_xtal_in  <= xtal_f;
                core_port_in  <= pin_in_f;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Serial output, launched on the falling test clock edge

    reg serial_bit;

    always @* begin
        if (state == ST_SHIR) begin
            serial_bit = ir_sh[0];
        end else if (is_bsr) begin
            serial_bit = bsr_tdo;
        end else begin
            serial_bit = dr_sh[0];
        end
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo    <= serial_bit;
            tdo_oe <= (state == ST_SHIR) | (state == ST_SHDR);
        end
    end
endmodule // jtbs_top

`default_nettype wire

// >>> include/jtbs_consts.vh
// Constants shared by the test access port and boundary scan block
`ifndef JTBS_CONSTS_VH
`define JTBS_CONSTS_VH

// Instruction register
`define JTBS_IR_W            16
`define JTBS_IR_RESET        16'h0000
`define JTBS_IR_CAPTURE      16'h0001
`define JTBS_OP_EXTEST       16'h0000
`define JTBS_OP_SAMPLE       16'h0002
`define JTBS_OP_IDCODE       16'h0004
`define JTBS_OP_BYPASS       16'hFFFF
`define JTBS_OP_FLASH_CTL    16'h0082
`define JTBS_OP_FLASH_DAT    16'h0083
`define JTBS_OP_FLASH_ADR    16'h0084
`define JTBS_OP_FLASH_SCL    16'h0085

// Identification register; default value is arbitrary, bit 0 set as usual
`define JTBS_ID_W            32
`define JTBS_ID_DEFAULT      32'h0ABC_D001

// Indirect flash access word
`define JTBS_FL_W            20
`define JTBS_FL_OP_HI        19
`define JTBS_FL_OP_LO        18
`define JTBS_FL_DATA_W       18
`define JTBS_FL_OP_READ      2'h2
`define JTBS_FL_OP_WRITE     2'h3

// Boundary chain layout
`define JTBS_BSR_LEN         134
`define JTBS_BSR_RST_SMALL   0
`define JTBS_BSR_RST_LARGE   2
`define JTBS_BSR_XTAL        4
`define JTBS_BSR_PULLUP      5
`define JTBS_BSR_PORT0       6
`define JTBS_PORT_PINS       64

`endif

// >>> verilog/jtbs_tap_fsm.v
// Test access port controller state machine, stepped on sampled test clock rises
`timescale 1ns/100ps
`default_nettype none

module jtbs_tap_fsm (
    input  wire       mclk,
    input  wire       rstn,
    input  wire       tck_rise,
    input  wire       tms_bit,
    output reg  [3:0] state
);
    localparam [3:0] ST_TLR  = 4'h0;
    localparam [3:0] ST_RTI  = 4'h1;
    localparam [3:0] ST_SDR  = 4'h2;
    localparam [3:0] ST_CDR  = 4'h3;
    localparam [3:0] ST_SHDR = 4'h4;
    localparam [3:0] ST_E1DR = 4'h5;
    localparam [3:0] ST_PDR  = 4'h6;
    localparam [3:0] ST_E2DR = 4'h7;
    localparam [3:0] ST_UDR  = 4'h8;
    localparam [3:0] ST_SIR  = 4'h9;
    localparam [3:0] ST_CIR  = 4'hA;
    localparam [3:0] ST_SHIR = 4'hB;
    localparam [3:0] ST_E1IR = 4'hC;
    localparam [3:0] ST_PIR  = 4'hD;
    localparam [3:0] ST_E2IR = 4'hE;
    localparam [3:0] ST_UIR  = 4'hF;

    reg [3:0] next_state;

    always @* begin
        case (state)
            ST_TLR:  next_state = tms_bit ? ST_TLR  : ST_RTI;
            ST_RTI:  next_state = tms_bit ? ST_SDR  : ST_RTI;
            ST_SDR:  next_state = tms_bit ? ST_SIR  : ST_CDR;
            ST_CDR:  next_state = tms_bit ? ST_E1DR : ST_SHDR;
            ST_SHDR: next_state = tms_bit ? ST_E1DR : ST_SHDR;
            ST_E1DR: next_state = tms_bit ? ST_UDR  : ST_PDR;
            ST_PDR:  next_state = tms_bit ? ST_E2DR : ST_PDR;
            ST_E2DR: next_state = tms_bit ? ST_UDR  : ST_SHDR;
            ST_UDR:  next_state = tms_bit ? ST_SDR  : ST_RTI;
            ST_SIR:  next_state = tms_bit ? ST_TLR  : ST_CIR;
            ST_CIR:  next_state = tms_bit ? ST_E1IR : ST_SHIR;
            ST_SHIR: next_state = tms_bit ? ST_E1IR : ST_SHIR;
            ST_E1IR: next_state = tms_bit ? ST_UIR  : ST_PIR;
            ST_PIR:  next_state = tms_bit ? ST_E2IR : ST_PIR;
            ST_E2IR: next_state = tms_bit ? ST_UIR  : ST_SHIR;
            ST_UIR:  next_state = tms_bit ? ST_SDR  : ST_RTI;
            default: next_state = ST_TLR;
        endcase
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_TLR;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end
endmodule // jtbs_tap_fsm

`default_nettype wire

// >>> verilog/jtbs_bsr.v
// Boundary shift chain with its update latches
`timescale 1ns/100ps
`default_nettype none
`include "jtbs_consts.vh"

module jtbs_bsr #(
    parameter LEN = `JTBS_BSR_LEN
) (
    input  wire           mclk,
    input  wire           rstn,
    input  wire           capture,
    input  wire           shift,
    input  wire           update,
    input  wire           tdi_bit,
    input  wire [LEN-1:0] cap_vec,
    output wire           tdo_bit,
    output reg  [LEN-1:0] upd_vec
);
    reg [LEN-1:0] chain;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            chain   <= {LEN{1'b0}};
            upd_vec <= {LEN{1'b0}};
        end else begin
            if (capture) begin
                chain <= cap_vec;
            end else if (shift) begin
                chain <= {tdi_bit, chain[LEN-1:1]};
            end
            // Latches hold still while shifting so pins do not ripple
            if (update) begin
                upd_vec <= chain;
            end
        end
    end

    assign tdo_bit = chain[0];
endmodule // jtbs_bsr

`default_nettype wire

// >>> bench/jtbs_tester.sv
// Test controller model driving the four-pin test port
`timescale 1ns/100ps
`default_nettype none

module jtbs_tester (
    output var logic tck,
    output var logic tms,
    output var logic tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // One 160 ns period; tck stands low between frames
    task automatic clk(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #80 tck = 1'b1;
        // Late in the high phase, after the previous fall has settled tdo
        #70 o = tdo;
        #10 tck = 1'b0;
    endtask
    task automatic tlr();
        logic o;
        repeat (5) clk(1'b1, 1'b0, o);
        clk(1'b0, 1'b0, o);
    endtask
    // Shift len bits LSB first through IR or DR, then update and idle
    task automatic scan(input bit ir, input int len, input logic [133:0] din,
                        output logic [133:0] dout);
        logic o;
        dout = '0;
        clk(1'b1, 1'b0, o);
        if (ir) begin
            clk(1'b1, 1'b0, o);
        end
        clk(1'b0, 1'b0, o);
        clk(1'b0, 1'b0, o);
        for (int i = 0; i < len; i++) begin
            clk(i == len - 1, din[i], o);
            dout[i] = o;
        end
        clk(1'b1, 1'b0, o);
        clk(1'b0, 1'b0, o);
    endtask
endmodule // jtbs_tester
`default_nettype wire

// >>> bench/jtbs_checker_sva.sv
// Concurrent checks on the test port block outputs
`timescale 1ns/100ps
`default_nettype none

module jtbs_checker #(
    parameter PINS = 64
) (
    input wire logic            mclk,
    input wire logic            rstn,
    input wire logic            core_pullup_en,
    input wire logic [PINS-1:0] core_port_oe,
    input wire logic [PINS-1:0] core_port_out,
    input wire logic [PINS-1:0] port_pin_oe,
    input wire logic [PINS-1:0] port_pin_out,
    input wire logic            pullup_en_out,
    input wire logic            core_rst_in,
    input wire logic            core_xtal_in,
    input wire logic [PINS-1:0] core_port_in,
    input wire logic            flash_req,
    input wire logic [1:0]      flash_req_sel,
    input wire logic [1:0]      flash_req_op,
    input wire logic            extest_active,
    input wire logic [15:0]     instruction
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////
    a_ext_on: assert property ((instruction == 16'h0000) [*2] |-> extest_active)
        else $error("drive test flag low with code zero");
    a_ext_off: assert property ((instruction != 16'h0000) [*2] |-> !extest_active)
        else $error("drive test flag high with other code");
    a_core_forced: assert property (extest_active && $past(extest_active)
        |-> core_rst_in && core_xtal_in && (&core_port_in))
        else $error("core input not forced high");
    a_pins_oe: assert property (!extest_active [*2] |-> port_pin_oe == $past(core_port_oe))
        else $error("pin enable not from core");
    a_pins_lvl: assert property (!extest_active [*2]
        |-> port_pin_out == $past(core_port_out) && pullup_en_out == $past(core_pullup_en))
        else $error("pin level not from core");
    a_req_pulse: assert property (flash_req |=> !flash_req)
        else $error("flash request longer than one cycle");
    a_req_op: assert property (flash_req |-> flash_req_op[1])
        else $error("flash request for poll");
    a_req_sel: assert property (flash_req |-> instruction >= 16'h0082
        && instruction <= 16'h0085 && flash_req_sel == instruction[1:0] + 2'h2)
        else $error("flash request select wrong");
    c_req: cover property (flash_req);
    c_ext_exit: cover property ($fell(extest_active));
    c_ext_enter: cover property ($rose(extest_active));
endmodule // jtbs_checker

bind jtbs_top jtbs_checker #(.PINS(PINS)) jtbs_checker_i (
    .mclk, .rstn, .core_pullup_en, .core_port_oe, .core_port_out, .port_pin_oe,
    .port_pin_out, .pullup_en_out, .core_rst_in, .core_xtal_in, .core_port_in,
    .flash_req, .flash_req_sel, .flash_req_op, .extest_active, .instruction
);
`default_nettype wire

// >>> bench/tb_jtbs_top.sv
// Self-checking bench for the test port block
`timescale 1ns/100ps
`default_nettype none
`include "jtbs_consts.vh"

module tb_jtbs_top;
    // Arbitrary identification value
    localparam logic [31:0] ID = 32'h1357_2469;
    logic mclk, rstn, tdo, tdo_oe, core_rst_en, core_rst_level, core_pullup_en;
    logic rst_pin_in, xtal_pin_in, flash_busy, rst_pin_oe, rst_pin_out, pullup_en_out;
    logic core_rst_in, core_xtal_in, flash_req, extest_active;
    logic [63:0] core_port_oe, core_port_out, port_pin_in, port_pin_oe, port_pin_out;
    logic [63:0] core_port_in;
    logic [1:0] flash_req_sel, flash_req_op;
    logic [17:0] flash_read_data, flash_req_data;
    logic [15:0] instruction;
    logic [133:0] d, pre;
    logic [21:0] req_last;
    wire logic tck, tms, tdi;
    int err_count, n_compared, req_cnt;
    // Set once the serial output enable has been seen high
    logic oe_seen = 1'b0;

    jtbs_top #(.ID_VALUE(ID), .LARGE_PKG(1), .PINS(64)) jtbs_top_i (
        .mclk, .rstn, .tck, .tms, .tdi, .tdo, .tdo_oe, .core_rst_en, .core_rst_level,
        .core_pullup_en, .core_port_oe, .core_port_out, .rst_pin_in, .xtal_pin_in,
        .port_pin_in, .rst_pin_oe, .rst_pin_out, .pullup_en_out, .port_pin_oe,
        .port_pin_out, .core_rst_in, .core_xtal_in, .core_port_in, .flash_busy,
        .flash_read_data, .flash_req, .flash_req_sel, .flash_req_op, .flash_req_data,
        .extest_active, .instruction
    );
    jtbs_tester jtbs_tester_i (.tck, .tms, .tdi, .tdo);

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (tdo_oe) begin
            oe_seen = 1'b1;
        end
        if (flash_req) begin
            req_cnt++;
            req_last = {flash_req_sel, flash_req_op, flash_req_data};
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [133:0] e, input logic [133:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("Compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (4) @(posedge mclk);
        #2;
    endtask
    task automatic ir(input logic [15:0] c);
        jtbs_tester_i.scan(1'b1, 16, {118'h0, c}, d);
    endtask
    function automatic logic [133:0] capv();
        logic [133:0] v;
        v[0] = core_rst_en;
        v[2] = core_rst_en;
        v[1] = rst_pin_in;
        v[3] = rst_pin_in;
        v[4] = xtal_pin_in;
        v[5] = core_pullup_en;
        for (int k = 0; k < 64; k++) begin
            v[6+2*k] = core_port_oe[k];
            v[7+2*k] = port_pin_in[k];
        end
        return v;
    endfunction
    function automatic logic [130:0] drv(input logic [133:0] v);
        logic [63:0] oe, o;
        for (int k = 0; k < 64; k++) begin
            oe[k] = v[6+2*k];
            o[k] = v[7+2*k];
        end
        return {v[2], v[3], v[5], oe, o};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        {core_rst_en, core_rst_level, core_pullup_en, rst_pin_in, xtal_pin_in} = 5'h0B;
        core_port_oe = 64'hF0F0_3C3C_0FF0_A55A;
        core_port_out = 64'h0F0F_C3C3_F00F_5AA5;
        port_pin_in = 64'h1234_5678_9ABC_DEF0;
        flash_busy = 1'b0;
        flash_read_data = 18'h2C35A;
        for (int i = 0; i < 134; i++) pre[i] = (i % 3 == 0);
        repeat (5) @(posedge mclk);
        #2 rstn = 1'b1;
        settle();
        chk("reset code", 16'h0000, instruction);
        chk("drive test flag", 1'b1, extest_active);
        chk("core ports", {64{1'b1}}, core_port_in);
        jtbs_tester_i.tlr();
        ir(16'h0004);
        chk("ir capture", 16'h0001, d[15:0]);
        jtbs_tester_i.scan(1'b0, 32, 134'h0, d);
        chk("id value", ID, d[31:0]);
        for (int i = 0; i < 2; i++) begin
            ir(i == 0 ? 16'hFFFF : 16'h1234);
            jtbs_tester_i.scan(1'b0, 9, 134'h0A5, d);
            chk("bypass", 9'h14A, d[8:0]);
        end
        // Boundary capture, preload without drive, then drive test
        ir(16'h0002);
        jtbs_tester_i.scan(1'b0, 134, pre, d);
        chk("sample capture", capv(), d);
        settle();
        chk("sample pins", {core_port_oe, core_port_out}, {port_pin_oe, port_pin_out});
        ir(16'h0000);
        settle();
        chk("preload drive", drv(pre), {rst_pin_oe, rst_pin_out, pullup_en_out,
            port_pin_oe, port_pin_out});
        jtbs_tester_i.scan(1'b0, 134, ~pre, d);
        chk("drive capture", capv(), d);
        settle();
        chk("update drive", drv(~pre), {rst_pin_oe, rst_pin_out, pullup_en_out,
            port_pin_oe, port_pin_out});
        chk("forced core", 3'h7, {core_rst_in, core_xtal_in, &core_port_in});
        // Each flash register gets one write
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk) #2 flash_busy = k[0];
            ir(16'h0082 + 16'(k));
            jtbs_tester_i.scan(1'b0, 20, {114'h0, 2'h3, 18'(k * 18'h0A5C3)}, d);
            chk("flash capture", {1'b0, flash_read_data, flash_busy}, d[19:0]);
            settle();
            chk("flash write", {2'(k), 2'h3, 18'(k * 18'h0A5C3)}, req_last);
        end
        jtbs_tester_i.scan(1'b0, 20, {114'h0, 20'h1FFFF}, d);
        settle();
        chk("poll count", 4, req_cnt);
        jtbs_tester_i.scan(1'b0, 2, 134'h2, d);
        settle();
        chk("short read", 4'hE, req_last[21:18]);
        chk("read count", 5, req_cnt);
        // Outside the drive test the core sees the filtered pin levels again
        chk("core pins", {rst_pin_in, xtal_pin_in, port_pin_in},
            {core_rst_in, core_xtal_in, core_port_in});
        chk("serial enable", 2'h2, {oe_seen, tdo_oe});
        close_out();
    end
    initial begin
        #1_000_000;
        err_count++;
        close_out();
    end
endmodule // tb_jtbs_top
`default_nettype wire
